/* include/rsc_map.vh */
// register offsets, field positions and reset values of the reset cause combiner
`ifndef RSC_MAP_VH
`define RSC_MAP_VH
`define RSC_CAUSE_OFFSET    12'h000
`define RSC_BIT_TRAP        15
`define RSC_BIT_BADOP       14
`define RSC_BIT_SWBOR       13
`define RSC_BIT_CFGMIS      9
`define RSC_BIT_PMBIAS      8
`define RSC_BIT_PIN         7
`define RSC_BIT_SOFT        6
`define RSC_BIT_SWWDT       5
`define RSC_BIT_WATCHDOG_TIMEOUT_FLAG        4
`define RSC_BIT_SLEEP       3
`define RSC_BIT_IDLE        2
`define RSC_BIT_BOR         1
`define RSC_BIT_POR         0
`define RSC_POR_VALUE       16'h0003
`define RSC_IMPL_MASK       16'hE3FF
`endif

/* core/rsc_reset_combiner.v */
// reset source combiner with reset cause and control register on apb
//
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "rsc_map.vh"

module rsc_reset_combiner (
  // clock and power-on reset
  input  wire        core_clk,
  input  wire        rst,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // reset sources, levels
  input  wire        masterClearPin,
  input  wire        softResetReq,
  input  wire        watchdogReset,
  input  wire        brownoutReset,
  input  wire        trapConflict,
  input  wire        badOpcode,
  input  wire        uninitWregReset,
  input  wire        configMismatch,
  // core events, one-cycle pulses
  input  wire        powerSaveSleep,
  input  wire        powerSaveIdle,
  // configuration fuses
  input  wire        watchdogFuse,
  input  wire        brownoutFuse,
  // outputs to core
  output reg         systemResetOut,
  output reg         brownoutEnable,
  output reg         watchdogEnable,
  output reg         progmemBiasInHalt
);

  ////////////////////////////////////////////////////////////////////////////
  // positions in the hardware event vector
  localparam integer EV_PIN    = 0;
  localparam integer EV_SOFT   = 1;
  localparam integer EV_WDT    = 2;
  localparam integer EV_BOR    = 3;
  localparam integer EV_TRAP   = 4;
  localparam integer EV_BADOP  = 5;
  localparam integer EV_UNINIT = 6;
  localparam integer EV_CFGMIS = 7;
  localparam integer EV_SLEEP  = 8;
  localparam integer EV_IDLE   = 9;
  localparam integer REG_WIDTH = 16;
  localparam [15:0]  IMPL_MASK = `RSC_IMPL_MASK;
  localparam [15:0]  POR_VALUE = `RSC_POR_VALUE;

  // reset sequencing states, one-hot
  localparam [1:0]   ST_FIXUP  = 2'b01;
  localparam [1:0]   ST_RUN    = 2'b10;

  ////////////////////////////////////////////////////////////////////////////
  reg  [15:0] cause_q;
  wire [15:0] cause_d;
  reg  [1:0]  state_q;
  reg  [1:0]  state_d;
  wire        running;
  wire [9:0]  events;
  wire        anySource;
  wire        access;
  wire        hit;
  wire        wrHit;
  wire        rdTake;
  wire        errTake;
  wire [15:0] readView;

  ////////////////////////////////////////////////////////////////////////////
  // 1 where a hardware event sets the given register bit
  function flagSet;
    input integer bitIdx;
    input [9:0]   ev;
    begin
      case (bitIdx)
        `RSC_BIT_TRAP: begin
          flagSet = ev[EV_TRAP];
        end
        `RSC_BIT_BADOP: begin
          flagSet = ev[EV_BADOP] | ev[EV_UNINIT];
        end
        `RSC_BIT_CFGMIS: begin
          flagSet = ev[EV_CFGMIS];
        end
        `RSC_BIT_PIN: begin
          flagSet = ev[EV_PIN];
        end
        `RSC_BIT_SOFT: begin
          flagSet = ev[EV_SOFT];
        end
        `RSC_BIT_WATCHDOG_TIMEOUT_FLAG: begin
          flagSet = ev[EV_WDT];
        end
        `RSC_BIT_SLEEP: begin
          flagSet = ev[EV_SLEEP];
        end
        `RSC_BIT_IDLE: begin
          flagSet = ev[EV_IDLE];
        end
        `RSC_BIT_BOR: begin
          flagSet = ev[EV_BOR];
        end
        default: begin
          flagSet = 1'b0;
        end
      endcase
    end
  endfunction

  // 1 where a hardware event clears the given register bit
  function flagClear;
    input integer bitIdx;
    input [9:0]   ev;
    begin
      case (bitIdx)
        `RSC_BIT_WATCHDOG_TIMEOUT_FLAG: begin
          flagClear = ev[EV_SLEEP] | ev[EV_IDLE];
        end
        default: begin
          flagClear = 1'b0;
        end
      endcase
    end
  endfunction

  // next value of one bit: write, then clear, then set, then fuse
  function nextFlag;
    input integer bitIdx;
    input         cur;
    input         wrEn;
    input         wrBit;
    input [9:0]   ev;
    input         borFuse;
    begin
      nextFlag = cur;
      if (wrEn) begin
        nextFlag = wrBit;
      end
      if (flagClear(bitIdx, ev)) begin
        nextFlag = 1'b0;
      end
      // a set beats a clear or a software write in the same cycle
      if (flagSet(bitIdx, ev)) begin
        nextFlag = 1'b1;
      end
      if ((bitIdx == `RSC_BIT_SWBOR) && !borFuse) begin
        nextFlag = 1'b0;
      end
    end
  endfunction

  // register as software sees it: holes read zero, bit 13 reads zero while the fuse is off
  function [15:0] regView;
    input [15:0] stored;
    input        borFuse;
    begin
      regView                 = stored & IMPL_MASK;
      regView[`RSC_BIT_SWBOR] = stored[`RSC_BIT_SWBOR] & borFuse;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  assign events    = {powerSaveIdle, powerSaveSleep, configMismatch, uninitWregReset, badOpcode,
                      trapConflict, brownoutReset, watchdogReset, softResetReq, masterClearPin};
  assign anySource = |events[EV_CFGMIS:EV_PIN];
  assign access    = psel & penable;
  assign hit       = (paddr == `RSC_CAUSE_OFFSET);
  // a write lands only on the edge that completes the transfer
  assign wrHit     = access & pready & pwrite & hit;
  assign rdTake    = access & ~pready & ~pwrite & hit;
  assign errTake   = access & ~pready & ~hit;
  // fuse hides bit 13; while it is off the next-value logic also clears the stored bit
  assign readView  = regView(cause_q, brownoutFuse);
  assign running   = (state_q == ST_RUN);

  ////////////////////////////////////////////////////////////////////////////
  // one copy of the flag logic per implemented register bit; holes tie to zero
  genvar gi;
  generate
    for (gi = 0; gi < REG_WIDTH; gi = gi + 1) begin : gFlag
      if (IMPL_MASK[gi]) begin : gImpl
        assign cause_d[gi] = nextFlag(gi, cause_q[gi], wrHit, pwdata[gi], events,
                                      brownoutFuse);
      end else begin : gHole
        assign cause_d[gi] = 1'b0;
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // one fix-up cycle after release, in which the fuse is loaded into bit 13;
  // an illegal code falls back to fix-up, which costs one more reset cycle
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_FIXUP: begin
        state_d = ST_RUN;
      end
      ST_RUN: begin
        state_d = ST_RUN;
      end
      default: begin
        state_d = ST_FIXUP;
      end
    endcase
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_FIXUP;
    end else begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power-on value; the software brown-out bit is loaded in the fix-up cycle
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cause_q <= POR_VALUE;
    end else if (!running) begin
      cause_q                 <= POR_VALUE;
      cause_q[`RSC_BIT_SWBOR] <= brownoutFuse;
    end else begin
      cause_q <= cause_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all registered; reset held through the fix-up cycle
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      systemResetOut <= 1'b1;
    end else begin
      systemResetOut <= anySource | ~running;
    end
  end

  // brown-out detection stays off until the fuse has been looked at
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      brownoutEnable <= 1'b0;
    end else begin
      brownoutEnable <= cause_d[`RSC_BIT_SWBOR] & brownoutFuse & running;
    end
  end

  // the fuse overrides a cleared software enable
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      watchdogEnable <= 1'b1;
    end else begin
      watchdogEnable <= watchdogFuse | cause_d[`RSC_BIT_SWWDT];
    end
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      progmemBiasInHalt <= 1'b0;
    end else begin
      progmemBiasInHalt <= cause_d[`RSC_BIT_PMBIAS];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb: one wait state, pready in second access cycle; unmapped gives slverr
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
    end else begin
      pready <= access & ~pready;
    end
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= errTake;
    end
  end

  // read data stands only with pready, so no stale word is ever seen
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h00000000;
    end else if (rdTake) begin
      prdata <= {16'h0000, readView};
    end else begin
      prdata <= 32'h00000000;
    end
  end

endmodule

`default_nettype wire

/* tb/rsc_reset_combiner_assertions.sv */
// checker on the reset combiner ports
`timescale 1ns/1ps
`default_nettype none
module rsc_checker (
  input wire logic        core_clk, rst, pready, pwrite, masterClearPin, watchdogReset,
  input wire logic        brownoutReset, watchdogFuse, brownoutFuse, systemResetOut,
  input wire logic        brownoutEnable, watchdogEnable,
  input wire logic [31:0] prdata
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  wire rdHit = pready && !pwrite;
  AST_ANY: assert property (masterClearPin |=> systemResetOut) else $error("src");
  AST_HOLD: assert property ($fell(systemResetOut) |-> !$past(brownoutReset))
    else $error("rel");
  AST_WDT: assert property (watchdogFuse [*2] |=> watchdogEnable) else $error("wdt");
  AST_BOR: assert property (!brownoutFuse [*2] |=> !brownoutEnable) else $error("bor");
  AST_ZERO: assert property (pready |-> (prdata & 32'hFFFF1C00) == 32'h0)
    else $error("zero");
  AST_PIN: assert property (rdHit && $past(masterClearPin, 2) |-> prdata[7])
    else $error("pin");
  AST_BORF: assert property (rdHit && $past(brownoutReset, 2) |-> prdata[1])
    else $error("borf");
  AST_WATCHDOG_TIMEOUT_FLAG: assert property (rdHit && $past(watchdogReset, 2) |-> prdata[4])
    else $error("watchdog_timeout_flag");
  cover property (rdHit && prdata[7]);
  cover property ($fell(systemResetOut));
  cover property (watchdogFuse && !brownoutFuse);
endmodule
bind rsc_reset_combiner rsc_checker chk (.*);
`default_nettype wire

/* tb/rsc_src_model.sv */
// partner: reset sources and core power-save events
`timescale 1ns/1ps
`default_nettype none
module rsc_src_model (
  input  wire logic       core_clk,
  input  wire logic [9:0] req,
  output var  logic [9:0] src
);
  logic [1:0] seen_q;
  // power-save events last one cycle however long the core asks
  always @(posedge core_clk) begin
    src    <= {req[9:8] & ~seen_q, req[7:0]};
    seen_q <= req[9:8];
  end
endmodule
`default_nettype wire

/* tb/tb.sv */
// self-checking bench for the reset cause combiner
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic core_clk, rst, psel, penable, pwrite, pready, pslverr, watchdogFuse, brownoutFuse;
  logic masterClearPin, softResetReq, watchdogReset, brownoutReset, trapConflict, badOpcode;
  logic uninitWregReset, configMismatch, powerSaveSleep, powerSaveIdle, systemResetOut;
  logic brownoutEnable, watchdogEnable, progmemBiasInHalt;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, d, expq[$];
  logic [9:0]  req;
  logic        errq[$];
  logic [15:0] acc;
  int errors, n_compared, bitPos[10] = '{7, 6, 4, 1, 15, 14, 14, 9, 3, 2};
  rsc_reset_combiner dut (.*);
  rsc_src_model model (.core_clk, .req, .src({powerSaveIdle, powerSaveSleep, configMismatch,
    uninitWregReset, badOpcode, trapConflict, brownoutReset, watchdogReset, softResetReq,
    masterClearPin}));
  task check(input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %0t %h %h", $time, seen, exp);
    end
  endtask
  task print_verdict;
    if (errors == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  function logic [31:0] lfsr(input logic [31:0] s);
    return s[0] ? (s >> 1) ^ 32'hA3000000 : s >> 1;
  endfunction
  task apb(input logic w, input logic [11:0] a, input logic [31:0] v);
    errq.push_back(a != 12'h000);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    expq.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  always @(posedge core_clk) if (pready && !pwrite) check(prdata, expq.pop_front());
  always @(posedge core_clk) if (pready) check({31'h0, pslverr}, {31'h0, errq.pop_front()});
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  initial begin
    #5000;
    errors++;
    print_verdict;
  end
  initial begin
    {rst, psel, penable, pwrite, paddr, pwdata, req, watchdogFuse} = '0;
    rst = 1'b1;
    brownoutFuse = 1'b1;
    d = 32'hD;
    acc = 16'h0;
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    rd(12'h000, 32'h00002003);
    apb(1'b1, 12'h000, 32'h0);
    // sources held across the read so the flag is seen while reset is active
    for (int i = 0; i < 10; i++) begin
      req <= 10'h001 << i;
      acc = acc & (i > 7 ? 16'hFFEF : 16'hFFFF) | 16'h0001 << bitPos[i];
      @(posedge core_clk);
      rd(12'h000, {16'h0, acc});
      check(systemResetOut, i < 8);
      req <= 10'h000;
      repeat (3) @(posedge core_clk);
      check(systemResetOut, 1'b0);
    end
    for (int k = 0; k < 6; k++) begin
      d = lfsr(d);
      watchdogFuse <= d[16];
      brownoutFuse <= d[17];
      apb(1'b1, 12'h000, d);
      rd(12'h000, d & 32'h0000E3FF & ~{18'h0, ~d[17], 13'h0});
      check({systemResetOut, brownoutEnable, watchdogEnable, progmemBiasInHalt},
        {1'b0, d[13] & d[17], d[5] | d[16], d[8]});
    end
    rd(12'h004, 32'h0);
    // second power-on in mid-run: everything but bits 1:0 and the fuse bit clears
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    rd(12'h000, {18'h0, brownoutFuse, 13'h0003});
    check(systemResetOut, 1'b0);
    print_verdict;
  end
endmodule
`default_nettype wire
